// File: rom_ctl_pkg.sv
// Purpose: shared constants for the serial rom command and busy control block
// Assumes: 32-bit axi4-lite register bus, 20 MHz reference clock
// Notes: offsets are byte addresses on the register bus
package rom_ctl_pkg;
  // register byte offsets
  localparam logic [7:0] CMD_OFS = 8'hB0;
  localparam logic [7:0] DATA_OFS = 8'hB4;
  localparam logic [7:0] IRQ_STS_OFS = 8'hB8;
  localparam logic [7:0] IRQ_MASK_OFS = 8'hBC;
  // command register fields
  localparam int CMD_BUSY_BIT = 31;
  localparam int CMD_OP_LSB = 28;
  localparam int OP_W = 3;
  localparam int CMD_TMO_BIT = 9;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // operation codes
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h3;
  // boot load address of the station address
  localparam logic [7:0] BOOT_ADDR = 8'h00;
  // interrupt status bit positions
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_TMO_BIT = 1;
  localparam int IRQ_W = 2;
  // timing
  localparam int CLK_HZ = 20000000;
  localparam int OP_TIMEOUT_US = 30000;
  localparam int OP_TIMEOUT_CYC = (OP_TIMEOUT_US / 1000) * (CLK_HZ / 1000);
  // reset values
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] MASK_RST = 2'h0;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_IDLE} op_state_e;
endpackage : rom_ctl_pkg

// File: rom_op_timer.sv
// Purpose: counts cycles of a running rom operation and flags expiry
// Assumes: start is a one-cycle pulse that restarts the count
// Notes: expired is a level that stays until the next start
`timescale 1ns/1ns
module rom_op_timer #(
  parameter int LIMIT = 600000
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic run_i,
  output logic expired_o
);
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic exp_ff;
  logic nxt_exp;

  // count only while the operation runs; saturate once expired
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_exp = exp_ff;
    if (start_i) begin
      nxt_cnt = 32'h0;
      nxt_exp = 1'b0;
    end else if (run_i && !exp_ff) begin
      nxt_cnt = cnt_ff + 32'h1;
      if (cnt_ff == 32'(LIMIT - 1)) begin
        nxt_exp = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 32'h0;
      exp_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      exp_ff <= nxt_exp;
    end
  end

  assign expired_o = exp_ff;
endmodule : rom_op_timer

// File: serial_rom_command_busy_control.sv
// Purpose: host command register and busy control in front of a serial rom engine
// Assumes: engine answers a request with a one-cycle done pulse on this clock
// Notes: register access over axi4-lite; one interrupt line from sticky events
`timescale 1ns/1ns
module serial_rom_command_busy_control
  import rom_ctl_pkg::*;
#(
  parameter int TIMEOUT_CYC = OP_TIMEOUT_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  output logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  input wire logic [7:0] S_AXI_ARADDR_I,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic ROM_REQ_O,
  output logic [2:0] ROM_OP_O,
  output logic [7:0] ROM_ADDR_O,
  output logic [7:0] ROM_WDATA_O,
  input wire logic ROM_DONE_I,
  input wire logic [7:0] ROM_RDATA_I,
  input wire logic ROM_PRESENT_I,
  output logic IRQ_O
);
  // bus channel state
  logic aw_ff, nxt_aw;
  logic [7:0] awaddr_ff, nxt_awaddr;
  logic w_ff, nxt_w;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  // block state
  op_state_e st_ff, nxt_st;
  logic [2:0] op_ff, nxt_op;
  logic [7:0] addr_ff, nxt_addr;
  logic [7:0] data_ff, nxt_data;
  logic tmo_ff, nxt_tmo;
  logic [1:0] sts_ff, nxt_sts;
  logic [1:0] mask_ff, nxt_mask;
  logic req_ff, nxt_req;
  // presence pin synchroniser
  logic pres_meta_ff, pres_ff;
  logic wr_go, start, expired, done_ok, busy;
  logic [31:0] cmd_view;

  assign busy = (st_ff != ST_IDLE);
  assign cmd_view = {busy, op_ff, 18'h0, tmo_ff, 1'b0, addr_ff};
  assign wr_go = aw_ff && w_ff && !bvalid_ff;
  // done from an absent rom is ignored so only the timeout can end it
  assign done_ok = ROM_DONE_I && pres_ff;
  assign start = req_ff;

  // presence is a board pin, so it crosses two flops first
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pres_meta_ff <= 1'b0;
      pres_ff <= 1'b0;
    end else begin
      pres_meta_ff <= ROM_PRESENT_I;
      pres_ff <= pres_meta_ff;
    end
  end

  rom_op_timer #(
    .LIMIT(TIMEOUT_CYC)
  ) u_timer (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .start_i(start),
    .run_i(st_ff == ST_RUN),
    .expired_o(expired)
  );

  // axi write and read channels; address and data may arrive in either order
  always_comb begin
    nxt_aw = aw_ff;
    nxt_awaddr = awaddr_ff;
    nxt_w = w_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      nxt_aw = 1'b1;
      nxt_awaddr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      nxt_w = 1'b1;
      nxt_wdata = S_AXI_WDATA_I;
      nxt_wstrb = S_AXI_WSTRB_I;
    end
    if (wr_go) begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = RESP_OKAY;
      if (awaddr_ff != CMD_OFS && awaddr_ff != DATA_OFS && awaddr_ff != IRQ_STS_OFS && awaddr_ff != IRQ_MASK_OFS) begin
        nxt_bresp = RESP_SLVERR;
      end
    end else if (bvalid_ff && S_AXI_BREADY_I) begin
      nxt_bvalid = 1'b0;
    end
    if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      case (S_AXI_ARADDR_I)
        CMD_OFS: nxt_rdata = cmd_view;
        DATA_OFS: nxt_rdata = {24'h0, data_ff};
        IRQ_STS_OFS: nxt_rdata = {30'h0, sts_ff};
        IRQ_MASK_OFS: nxt_rdata = {30'h0, mask_ff};
        default: begin
          nxt_rdata = 32'h0;
          nxt_rresp = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && S_AXI_RREADY_I) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      w_ff <= 1'b0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= 2'h0;
    end else begin
      aw_ff <= nxt_aw;
      awaddr_ff <= nxt_awaddr;
      w_ff <= nxt_w;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // operation control: boot load, host launch, completion and timeout
  always_comb begin
    nxt_st = st_ff;
    nxt_op = op_ff;
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    nxt_tmo = tmo_ff;
    nxt_sts = sts_ff;
    nxt_mask = mask_ff;
    nxt_req = 1'b0;
    // software clears first so that a same-cycle event below wins
    if (wr_go && awaddr_ff == CMD_OFS && wstrb_ff[1] && wdata_ff[CMD_TMO_BIT]) begin
      nxt_tmo = 1'b0;
    end
    if (wr_go && awaddr_ff == IRQ_STS_OFS && wstrb_ff[0]) begin
      nxt_sts = sts_ff & ~wdata_ff[IRQ_W-1:0];
    end
    if (wr_go && awaddr_ff == IRQ_MASK_OFS && wstrb_ff[0]) begin
      nxt_mask = wdata_ff[IRQ_W-1:0];
    end
    case (st_ff)
      ST_BOOT: begin
        // fetch the station address before the host may use the port
        nxt_op = OP_READ;
        nxt_addr = BOOT_ADDR;
        nxt_req = 1'b1;
        nxt_st = ST_RUN;
      end
      ST_RUN: begin
        if (done_ok) begin
          if (op_ff == OP_READ) begin
            nxt_data = ROM_RDATA_I;
          end
          nxt_sts[IRQ_DONE_BIT] = 1'b1;
          nxt_st = ST_IDLE;
        end else if (expired && !start) begin // timer still shows the last expiry until start clears it
          nxt_tmo = 1'b1;
          nxt_sts[IRQ_TMO_BIT] = 1'b1;
          nxt_st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // data and launch writes only land while idle, so a busy operation keeps its inputs
        if (wr_go && awaddr_ff == DATA_OFS && wstrb_ff[0]) begin
          nxt_data = wdata_ff[DATA_W-1:0];
        end
        if (wr_go && awaddr_ff == CMD_OFS && wstrb_ff[3] && wstrb_ff[0] && wdata_ff[CMD_BUSY_BIT]) begin
          nxt_op = wdata_ff[CMD_OP_LSB +: OP_W];
          nxt_addr = wdata_ff[ADDR_W-1:0];
          nxt_req = 1'b1;
          nxt_st = ST_RUN;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_ff <= ST_BOOT;
      op_ff <= OP_READ;
      addr_ff <= ADDR_RST;
      data_ff <= DATA_RST;
      tmo_ff <= 1'b0;
      sts_ff <= 2'h0;
      mask_ff <= MASK_RST;
      req_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      op_ff <= nxt_op;
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
      tmo_ff <= nxt_tmo;
      sts_ff <= nxt_sts;
      mask_ff <= nxt_mask;
      req_ff <= nxt_req;
    end
  end

  // outputs; bus readies are combinational handshakes
  assign S_AXI_AWREADY_O = !aw_ff;
  assign S_AXI_WREADY_O = !w_ff;
  assign S_AXI_BVALID_O = bvalid_ff;
  assign S_AXI_BRESP_O = bresp_ff;
  assign S_AXI_ARREADY_O = !rvalid_ff;
  assign S_AXI_RVALID_O = rvalid_ff;
  assign S_AXI_RDATA_O = rdata_ff;
  assign S_AXI_RRESP_O = rresp_ff;
  assign ROM_REQ_O = req_ff;
  assign ROM_OP_O = op_ff;
  assign ROM_ADDR_O = addr_ff;
  assign ROM_WDATA_O = data_ff;
  assign IRQ_O = |(sts_ff & mask_ff);
endmodule : serial_rom_command_busy_control

// File: rom_ctl_asserts.sv
// Purpose: port checks of the rom command block
// Assumes: one clock, asynchronous active-low reset
// Notes: busy is internal, so checks tie bus and engine pins
`timescale 1ns/1ns
module rom_ctl_asserts (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic ROM_REQ_O,
  input wire logic IRQ_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // engine and irq stay quiet while reset is held
  a_reset_quiet: assert property (disable iff (1'b0) !RST_N_I |-> !ROM_REQ_O && !IRQ_O)
    else $error("engine request or irq during reset");
  // station address load starts on the first edge after release
  a_boot_launch: assert property ($rose(RST_N_I) |=> ROM_REQ_O)
    else $error("no boot load after reset");
  // busy blocks a second launch right behind the first
  a_req_gap: assert property (ROM_REQ_O |=> !ROM_REQ_O [*2])
    else $error("engine request too soon");
  // both items are held one cycle, then the write lands and the response rises on the same edge
  a_b_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O |=> ##1 S_AXI_BVALID_O)
    else $error("write response late");
  a_b_stands: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O)
    else $error("write response dropped");
  a_r_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
    else $error("read data late");
  a_r_stands: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
    else $error("read data not held");
  a_ar_refuse: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
    else $error("read address taken while data pending");
  c_launch: cover property (ROM_REQ_O);
  c_irq: cover property (IRQ_O);
  c_rwait: cover property (S_AXI_RVALID_O && !S_AXI_RREADY_I);
endmodule : rom_ctl_asserts

// File: rom_model.sv
// Purpose: behavioural serial rom behind the engine port
// Assumes: cell a holds a ^ 5A until written
// Notes: idle data line toggles so stale bytes never look valid
`timescale 1ns/1ns
module rom_model
  import rom_ctl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic [2:0] op_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic present_i,
  input wire logic [7:0] lat_i,
  output logic done_o,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [256];
  logic [7:0] cnt;
  logic run;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  // absent rom never answers, so the block must time out
  always @(posedge clk_i or negedge rst_n_i) begin
    done_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (!rst_n_i) begin
      run <= 1'b0;
    end else if (req_i && present_i) begin
      run <= 1'b1;
      cnt <= lat_i;
    end else if (run && cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end else if (run) begin
      run <= 1'b0;
      done_o <= 1'b1;
      if (op_i == OP_WRITE) mem[addr_i] <= wdata_i;
      else rdata_o <= mem[addr_i];
    end
  end
endmodule : rom_model

// File: tb.sv
// Purpose: self-checking bench of the rom command block
// Assumes: axi4-lite master tasks, rom model on the engine side
// Notes: timeout shortened to 20 cycles to keep absent-rom runs short
`timescale 1ns/1ns
module tb
  import rom_ctl_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, present = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic bv, rv, awrdy, wrdy, arrdy, req, done, irq;
  logic [7:0] awa = 8'h00, ara = 8'h00, lat = 8'h08, addr, rwd, rrd;
  logic [31:0] wd = 32'h0, rdat, v;
  logic [2:0] op;
  logic [1:0] bresp, rresp, r;
  int err_count = 0, checks_done = 0, cycles = 0;
  serial_rom_command_busy_control #(.TIMEOUT_CYC(20)) i_dut (.REF_CLK_I(clk), .RST_N_I(rst_n),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awrdy), .S_AXI_AWADDR_I(awa), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wrdy), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(br), .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arrdy),
    .S_AXI_ARADDR_I(ara), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .S_AXI_RDATA_O(rdat),
    .S_AXI_RRESP_O(rresp), .ROM_REQ_O(req), .ROM_OP_O(op), .ROM_ADDR_O(addr), .ROM_WDATA_O(rwd),
    .ROM_DONE_I(done), .ROM_RDATA_I(rrd), .ROM_PRESENT_I(present), .IRQ_O(irq));
  rom_model i_rom (.clk_i(clk), .rst_n_i(rst_n), .req_i(req), .op_i(op), .addr_i(addr),
    .wdata_i(rwd), .present_i(present), .lat_i(lat), .done_o(done), .rdata_o(rrd));
  always #25 clk = ~clk;
  // hang guard: whole sequence needs well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] s);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && awrdy) begin
        pa = 1'b0;
        awv <= 1'b0;
      end
      if (pw && wrdy) begin
        pw = 1'b0;
        wv <= 1'b0;
      end
    end
    while (!bv) @(posedge clk);
    br <= 1'b1;
    @(posedge clk);
    s = bresp;
    br <= 1'b0;
  endtask : wr
  // ready raised only after valid is seen, so the slave must hold its answer
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
    ara <= a;
    arv <= 1'b1;
    do @(posedge clk); while (!arrdy);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rr <= 1'b1;
    @(posedge clk);
    d = rdat;
    s = rresp;
    rr <= 1'b0;
  endtask : rd
  task automatic wait_idle(output logic [31:0] q);
    logic [1:0] s;
    q = 32'hFFFFFFFF;
    for (int i = 0; i < 60 && q[CMD_BUSY_BIT] !== 1'b0; i++) rd(CMD_OFS, q, s);
    chk("busy cleared", 32'h0, {31'h0, q[CMD_BUSY_BIT]});
  endtask : wait_idle
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(CMD_OFS, v, r);
    chk("boot busy", 32'h1, {31'h0, v[CMD_BUSY_BIT]});
    wait_idle(v);
    rd(DATA_OFS, v, r);
    chk("boot data", {24'h0, BOOT_ADDR ^ 8'h5A}, v);
    lat <= 8'h06;
    wr(CMD_OFS, 32'h80000005, r);
    chk("launch resp", {30'h0, RESP_OKAY}, {30'h0, r});
    rd(CMD_OFS, v, r);
    chk("op busy", 32'h1, {31'h0, v[CMD_BUSY_BIT]});
    wait_idle(v);
    rd(DATA_OFS, v, r);
    chk("read data", 32'h5F, v);
    // done event: masked, unmasked, then cleared by writing ones
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(IRQ_MASK_OFS, 32'h3, r);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(IRQ_STS_OFS, 32'h3, r);
    chk("irq cleared", 32'h0, {31'h0, irq});
    lat <= 8'h00;
    wr(DATA_OFS, 32'hA7, r);
    wr(CMD_OFS, 32'hB0000010, r);
    wait_idle(v);
    wr(CMD_OFS, 32'h80000010, r);
    wait_idle(v);
    rd(DATA_OFS, v, r);
    chk("written byte", 32'hA7, v);
    present <= 1'b0;
    repeat (3) @(posedge clk);
    wr(CMD_OFS, 32'hB0000020, r);
    rd(CMD_OFS, v, r);
    chk("absent busy", 32'h1, {31'h0, v[CMD_BUSY_BIT]});
    wait_idle(v);
    chk("timeout flag", 32'h1, {31'h0, v[CMD_TMO_BIT]});
    rd(IRQ_STS_OFS, v, r);
    chk("timeout event", 32'h1, {31'h0, v[IRQ_TMO_BIT]});
    chk("timeout irq", 32'h1, {31'h0, irq});
    rd(8'hC0, v, r);
    chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(8'hC4, 32'h1, r);
    chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
    // clear the timeout flag, then a relaunch must not inherit the old expiry
    wr(CMD_OFS, 32'h00000200, r);
    rd(CMD_OFS, v, r);
    chk("timeout cleared", 32'h0, {31'h0, v[CMD_TMO_BIT]});
    present <= 1'b1;
    lat <= 8'h06;
    repeat (3) @(posedge clk);
    wr(CMD_OFS, 32'h80000005, r);
    rd(CMD_OFS, v, r);
    chk("relaunch busy", 32'h1, {31'h0, v[CMD_BUSY_BIT]});
    wait_idle(v);
    chk("relaunch no timeout", 32'h0, {31'h0, v[CMD_TMO_BIT]});
    rd(DATA_OFS, v, r);
    chk("relaunch data", 32'h5F, v);
    present <= 1'b0;
    // second reset with no rom: boot load must give up by timeout
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(CMD_OFS, v, r);
    chk("reset busy", 32'h1, {31'h0, v[CMD_BUSY_BIT]});
    wait_idle(v);
    wrap_up();
  end
endmodule : tb
bind serial_rom_command_busy_control rom_ctl_asserts i_chk (.*);
